//--- port_pkg.sv
// package of constants and carrier types for the quasi-bidirectional port logic
package port_pkg;

   // ****************************************************************
   // register map (apb byte addresses)
   // ****************************************************************
   localparam logic [11:0] port0_off = 12'h000;
   localparam logic [11:0] port1_off = 12'h004;
   localparam logic [11:0] port2_off = 12'h008;
   localparam logic [11:0] port3_off = 12'h00c;
   localparam logic [11:0] port4_off = 12'h010;
   localparam logic [11:0] port5_off = 12'h014;
   localparam logic [11:0] ana_off = 12'h018;
   localparam logic [11:0] ctrl_off = 12'h01c;
   localparam logic [11:0] pin0_off = 12'h020;
   localparam logic [11:0] pin1_off = 12'h024;
   localparam logic [11:0] pin2_off = 12'h028;
   localparam logic [11:0] pin3_off = 12'h02c;
   localparam logic [11:0] pin4_off = 12'h030;
   localparam logic [11:0] pin5_off = 12'h034;

   // ****************************************************************
   // reset values and field positions
   // ****************************************************************
   localparam logic [7:0] latch_rst = 8'hff;
   localparam logic [5:0] latch5_rst = 6'h3f;
   localparam logic [7:0] ana_rst = 8'hff;
   localparam int ctrl_ext_bit = 0;
   localparam int ctrl_a16_bit = 1;
   localparam logic [1:0] ctrl_rst = 2'h0;

   // ****************************************************************
   // timing: boost lasts two oscillator periods of 25 ns each
   // ****************************************************************
   localparam int osc_period_ns = 25;
   localparam int boost_time_ns = 50;
   localparam int boost_cycles_i = (boost_time_ns + osc_period_ns - 1) / osc_period_ns;
   localparam logic [1:0] boost_cycles = 2'(boost_cycles_i);

   typedef enum {weak_input_low, input_high_state, boosted_high_state, driving_low_state} drv_state_e;

   // pin driver controls of one bit
   typedef struct packed {
      logic pulldown_driver;
      logic boost_pullup;
      logic weak_pullup;
      logic keeper_pullup;
   } drv_s;

endpackage

//--- quasi_bidir_port_logic.sv
// quasi-bidirectional six-port logic with apb register access
// Notes on behaviour
// - a latch write captures write data into that port latch
// - latch-read returns stored latch contents, not the pin level
// - reads pick latch (port offsets) or sampled pin (pin offsets)
// - ports 1-5 act as input only while latch holds 1
// - port 0 pullup on only when emitting ones in external cycles
// - port 0 latch 1 in i/o use: both drivers off, floating
// - alternate functions on ports 1 and 3 pass only when latch is 1
// - reset sets every port latch bit to 1
// - ports 0 and 2 switch to external bus by external-access control
// - while on external bus, latches disconnected and kept unchanged
// - 16-bit external cycles: port 2 drives ones with strong pullup
// - port 0 is general i/o when no external cycles run
// - strong pulldown only while latch holds 0
// - 0-to-1 latch change enables boost for exactly two periods
// - weak pullup on whenever latch holds 1
// - keeper on while sensed pin is high, and throughout the boost
// - driver takes one of four states with fixed transistor sets
// - 1 into 0 latch: boosted two cycles then steady; 1 into 1: none
// - loading 0 puts pin into driving-low state
// - after reset pins are input-low until sensed pin goes high
// - analog-selected port 1 pin has all four drivers off
// - analog select bit 0 makes analog input; reset value all digital
module quasi_bidir_driver
   import port_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic latch_bit,
   input wire logic pin_high,
   input wire logic force_off,
   output drv_s drv
);
   drv_state_e state_r;
   drv_state_e state_nxt;
   logic latch_q_r;
   logic [1:0] boost_cnt_r;
   logic [1:0] boost_cnt_nxt;
   logic rising;

   assign rising = latch_bit && !latch_q_r;

   // ****************************************************************
   // driver state machine
   // ****************************************************************

   always_comb
   begin
      state_nxt = state_r;
      boost_cnt_nxt = boost_cnt_r;
      if (!latch_bit)
      begin
         state_nxt = driving_low_state;
         boost_cnt_nxt = 2'h0;
      end
      else if (rising)
      begin
         state_nxt = boosted_high_state;
         boost_cnt_nxt = boost_cycles - 2'h1;
      end
      else
      begin
         case (state_r)
            boosted_high_state:
            begin
               if (boost_cnt_r == 2'h0)
               begin
                  state_nxt = pin_high ? input_high_state : weak_input_low;
               end
               else
               begin
                  boost_cnt_nxt = boost_cnt_r - 2'h1;
               end
            end
            weak_input_low: state_nxt = pin_high ? input_high_state : weak_input_low;
            input_high_state: state_nxt = pin_high ? input_high_state : weak_input_low;
            driving_low_state: state_nxt = weak_input_low;
            default: state_nxt = weak_input_low;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_r <= weak_input_low;
         latch_q_r <= 1'b1;
         boost_cnt_r <= 2'h0;
      end
      else
      begin
         state_r <= state_nxt;
         latch_q_r <= latch_bit;
         boost_cnt_r <= boost_cnt_nxt;
      end
   end

   // ****************************************************************
   // transistor enables: analog select overrides every transistor
   // ****************************************************************
   always_comb
   begin
      drv = '0;
      if (!force_off)
      begin
         case (state_r)
            weak_input_low: drv.weak_pullup = 1'b1;
            input_high_state:
            begin
               drv.weak_pullup = 1'b1;
               drv.keeper_pullup = 1'b1;
            end
            boosted_high_state:
            begin
               drv.boost_pullup = 1'b1;
               drv.weak_pullup = 1'b1;
               drv.keeper_pullup = 1'b1;
            end
            driving_low_state: drv.pulldown_driver = 1'b1;
            default: drv = '0;
         endcase
      end
   end
endmodule

module quasi_bidir_port_logic
   import port_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [7:0] p0_in,
   input wire logic [7:0] p1_in,
   input wire logic [7:0] p2_in,
   input wire logic [7:0] p3_in,
   input wire logic [7:0] p4_in,
   input wire logic [5:0] p5_in,
   input wire logic external_access_pin,
   input wire logic ext_cycle,
   input wire logic [7:0] ext_addr_hi,
   input wire logic [7:0] ext_ad_out,
   input wire logic ext_ad_drive,
   output logic [7:0] ext_ad_in,
   input wire logic [7:0] p1_alt_out,
   input wire logic [7:0] p3_alt_out,
   output logic [7:0] p1_alt_in,
   output logic [7:0] p3_alt_in,
   output logic [7:0] p0_pulldown,
   output logic [7:0] p0_pullup,
   output drv_s [7:0] p1_drv,
   output drv_s [7:0] p2_drv,
   output drv_s [7:0] p3_drv,
   output drv_s [7:0] p4_drv,
   output drv_s [5:0] p5_drv
);
   // ****************************************************************
   // pin synchronisers
   // ****************************************************************
   logic [45:0] pin_meta_r;
   logic [45:0] pin_sync_r;
   logic ea_meta_r;
   logic ea_sync_r;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pin_meta_r <= '0;
         pin_sync_r <= '0;
         ea_meta_r <= 1'b0;
         ea_sync_r <= 1'b0;
      end
      else
      begin
         pin_meta_r <= {p5_in, p4_in, p3_in, p2_in, p1_in, p0_in};
         pin_sync_r <= pin_meta_r;
         ea_meta_r <= external_access_pin;
         ea_sync_r <= ea_meta_r;
      end
   end

   wire [7:0] p0_pin = pin_sync_r[7:0];
   wire [7:0] p1_pin = pin_sync_r[15:8];
   wire [7:0] p2_pin = pin_sync_r[23:16];
   wire [7:0] p3_pin = pin_sync_r[31:24];
   wire [7:0] p4_pin = pin_sync_r[39:32];
   wire [5:0] p5_pin = pin_sync_r[45:40];

   // ****************************************************************
   // apb decode and registers
   // ****************************************************************
   logic [7:0] p0_r;
   logic [7:0] p1_r;
   logic [7:0] p2_r;
   logic [7:0] p3_r;
   logic [7:0] p4_r;
   logic [5:0] p5_r;
   logic [7:0] analog_select_reg_r;
   logic [1:0] ctrl_r;

   wire wr_en = psel && penable && pwrite;
   wire wr_p0 = wr_en && (paddr == port0_off);
   wire wr_p1 = wr_en && (paddr == port1_off);
   wire wr_p2 = wr_en && (paddr == port2_off);
   wire wr_p3 = wr_en && (paddr == port3_off);
   wire wr_p4 = wr_en && (paddr == port4_off);
   wire wr_p5 = wr_en && (paddr == port5_off);
   wire wr_ana = wr_en && (paddr == ana_off);
   wire wr_ctrl = wr_en && (paddr == ctrl_off);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         p0_r <= latch_rst;
         p1_r <= latch_rst;
         p2_r <= latch_rst;
         p3_r <= latch_rst;
         p4_r <= latch_rst;
         p5_r <= latch5_rst;
         analog_select_reg_r <= ana_rst;
         ctrl_r <= ctrl_rst;
      end
      else
      begin
         if (wr_p0) p0_r <= pwdata[7:0];
         if (wr_p1) p1_r <= pwdata[7:0];
         if (wr_p2) p2_r <= pwdata[7:0];
         if (wr_p3) p3_r <= pwdata[7:0];
         if (wr_p4) p4_r <= pwdata[7:0];
         if (wr_p5) p5_r <= pwdata[5:0];
         if (wr_ana) analog_select_reg_r <= pwdata[7:0];
         if (wr_ctrl) ctrl_r <= pwdata[1:0];
      end
   end

   // latch offsets model read-modify-write reads, pin offsets plain reads
   logic [31:0] rd_mux;
   logic rd_hit;
   always_comb
   begin
      rd_hit = 1'b1;
      case (paddr)
         port0_off: rd_mux = {24'h0, p0_r};
         port1_off: rd_mux = {24'h0, p1_r};
         port2_off: rd_mux = {24'h0, p2_r};
         port3_off: rd_mux = {24'h0, p3_r};
         port4_off: rd_mux = {24'h0, p4_r};
         port5_off: rd_mux = {26'h0, p5_r};
         ana_off: rd_mux = {24'h0, analog_select_reg_r};
         ctrl_off: rd_mux = {30'h0, ctrl_r};
         pin0_off: rd_mux = {24'h0, p0_pin};
         pin1_off: rd_mux = {24'h0, p1_pin};
         pin2_off: rd_mux = {24'h0, p2_pin};
         pin3_off: rd_mux = {24'h0, p3_pin};
         pin4_off: rd_mux = {24'h0, p4_pin};
         pin5_off: rd_mux = {26'h0, p5_pin};
         default:
         begin
            rd_mux = 32'h0;
            rd_hit = 1'b0;
         end
      endcase
   end

   // read word captured in the setup cycle so it stands, from a flop, through the access cycle
   logic [31:0] rd_data_r;
   wire rd_setup = psel && !penable && !pwrite;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rd_data_r <= 32'h0;
      end
      else
      begin
         rd_data_r <= rd_setup ? rd_mux : 32'h0;
      end
   end

   assign pready = 1'b1;
   assign pslverr = psel && penable && !rd_hit;
   assign prdata = rd_data_r;

   // ****************************************************************
   // external bus takeover of ports 0 and 2
   // ****************************************************************
   // without the pin, the control bit alone lets software route ports 0 and 2
   wire ext_mode = ea_sync_r || ctrl_r[ctrl_ext_bit];
   wire bus_active = ext_mode && ext_cycle;
   wire a16 = bus_active && ctrl_r[ctrl_a16_bit];

   // ports 0: open drain, pullup only for bus ones
   assign p0_pulldown = bus_active ? (ext_ad_drive ? ~ext_ad_out : 8'h0) : ~p0_r;
   assign p0_pullup = (bus_active && ext_ad_drive) ? ext_ad_out : 8'h0;
   assign ext_ad_in = p0_pin;

   // ****************************************************************
   // multifunction drivers of ports 1 to 5
   // ****************************************************************
   // alternate output gated by latch: and-ing keeps pin low when latch is 0
   wire [7:0] p1_eff = p1_r & p1_alt_out;
   wire [7:0] p3_eff = p3_r & p3_alt_out;
   assign p1_alt_in = p1_pin & p1_r;
   assign p3_alt_in = p3_pin & p3_r;
   wire [7:0] p2_eff = a16 ? ext_addr_hi : p2_r;
   drv_s [7:0] p2_base;

   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++)
      begin : g_bit
         quasi_bidir_driver u_p1
         (
            .pclk(pclk),
            .presetn(presetn),
            .latch_bit(p1_eff[gi]),
            .pin_high(p1_pin[gi]),
            .force_off(!analog_select_reg_r[gi]),
            .drv(p1_drv[gi])
         );
         quasi_bidir_driver u_p2
         (
            .pclk(pclk),
            .presetn(presetn),
            .latch_bit(p2_eff[gi]),
            .pin_high(p2_pin[gi]),
            .force_off(1'b0),
            .drv(p2_base[gi])
         );
         quasi_bidir_driver u_p3
         (
            .pclk(pclk),
            .presetn(presetn),
            .latch_bit(p3_eff[gi]),
            .pin_high(p3_pin[gi]),
            .force_off(1'b0),
            .drv(p3_drv[gi])
         );
         quasi_bidir_driver u_p4
         (
            .pclk(pclk),
            .presetn(presetn),
            .latch_bit(p4_r[gi]),
            .pin_high(p4_pin[gi]),
            .force_off(1'b0),
            .drv(p4_drv[gi])
         );
         // strong ones for the whole 16-bit address cycle
         assign p2_drv[gi] = (a16 && ext_addr_hi[gi]) ? drv_s'{1'b0, 1'b1, 1'b0, 1'b0} : p2_base[gi];
      end
      for (gi = 0; gi < 6; gi++)
      begin : g_p5
         quasi_bidir_driver u_p5
         (
            .pclk(pclk),
            .presetn(presetn),
            .latch_bit(p5_r[gi]),
            .pin_high(p5_pin[gi]),
            .force_off(1'b0),
            .drv(p5_drv[gi])
         );
      end
   endgenerate
endmodule

//--- port_checker_sva.sv
// concurrent checks of the port driver behaviour at the block's ports
module port_checker
   import port_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [7:0] p1_in,
   input wire logic ext_cycle,
   input wire logic [7:0] p0_pulldown,
   input wire logic [7:0] p0_pullup,
   input wire drv_s [7:0] p1_drv,
   input wire drv_s [7:0] p4_drv
);
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // all-off is legal on any port 1 pin, where analog select applies, never on port 4
   function automatic logic legal(drv_s [7:0] d, logic off_ok);
      legal = 1'b1;
      for (int i = 0; i < 8; i++)
         if (!((4'(d[i]) inside {4'h2, 4'h3, 4'h7, 4'h8}) || (off_ok && 4'(d[i]) == 4'h0)))
            legal = 1'b0;
   endfunction
   sequence p1_wr(logic v);
      psel && penable && pwrite && paddr == port1_off && pwdata[0] == v;
   endsequence
   sequence boost_pulse;
      p1_drv[0].boost_pullup [*2] ##1 !p1_drv[0].boost_pullup;
   endsequence
   load_zero_a: assert property (p1_wr(1'b0) |-> ##2 p1_drv[0] == drv_s'(4'h8))
      else $error("port 1 bit 0 not driving low after a 0 write");
   weak_on_one_a: assert property (p1_wr(1'b1) |-> ##2 p1_drv[0].weak_pullup [*2])
      else $error("weak pullup off although latch holds 1");
   boost_pair_a: assert property ($rose(p1_drv[0].boost_pullup) |-> boost_pulse)
      else $error("boost pulse not exactly two cycles");
   boost_cause_a: assert property ($rose(p1_drv[0].boost_pullup) |-> $past(p1_drv[0].pulldown_driver))
      else $error("boost without preceding low drive");
   keeper_sense_a: assert property (p1_drv[0].keeper_pullup && !p1_drv[0].boost_pullup |-> $past(p1_in[0], 3))
      else $error("keeper on while pin sensed low");
   p0_open_drain_a: assert property (!ext_cycle |-> p0_pullup == 8'h00)
      else $error("port 0 pullup on outside bus cycles");
   p0_no_fight_a: assert property ((p0_pullup & p0_pulldown) == 8'h00)
      else $error("port 0 pullup and pulldown both on");
   legal_state_a: assert property (legal(p1_drv, 1'b1) && legal(p4_drv, 1'b0))
      else $error("driver controls outside the four states");
   reset_weak_a: assert property ($rose(presetn) |-> p1_drv[0] == drv_s'(4'h2))
      else $error("driver not weak input low at reset release");
endmodule

bind quasi_bidir_port_logic port_checker chk_u (.*);

//--- pin_load_model.sv
// external circuitry on the port pins: pull-up resistors and optional pull-low sources
module pin_load_model
   import port_pkg::*;
(
   input wire logic [7:0] p0_pulldown,
   input wire logic [7:0] p0_pullup,
   input wire drv_s [7:0] p1_drv,
   input wire drv_s [7:0] p2_drv,
   input wire drv_s [7:0] p3_drv,
   input wire drv_s [7:0] p4_drv,
   input wire drv_s [5:0] p5_drv,
   input wire logic [7:0] ext_low,
   output logic [7:0] p0_in,
   output logic [7:0] p1_in,
   output logic [7:0] p2_in,
   output logic [7:0] p3_in,
   output logic [7:0] p4_in,
   output logic [5:0] p5_in
);
   logic [7:0] p5_full;
   // a pulling source overpowers the weak pullups, not the pulldown
   function automatic logic [7:0] lvl(drv_s [7:0] d, logic [7:0] lo);
      for (int i = 0; i < 8; i++)
         lvl[i] = !d[i].pulldown_driver && !lo[i];
   endfunction
   // port 0 relies on board pull-ups when floating
   assign p0_in = (p0_pullup | ~p0_pulldown) & ~ext_low;
   assign p1_in = lvl(p1_drv, ext_low);
   assign p2_in = lvl(p2_drv, ext_low);
   assign p3_in = lvl(p3_drv, ext_low);
   assign p4_in = lvl(p4_drv, ext_low);
   assign p5_full = lvl({8'h00, p5_drv}, ext_low);
   assign p5_in = p5_full[5:0];
endmodule

//--- tb_top.sv
// testbench: register traffic over apb and driver checks for the port logic
module tb_top
   import port_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic external_access_pin = 1'b0, ext_cycle = 1'b0, ext_ad_drive = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rdv, bst;
   logic pready, pslverr, err;
   logic [7:0] p0_in, p1_in, p2_in, p3_in, p4_in, ext_ad_in, p1_alt_in, p3_alt_in, p0_pulldown, p0_pullup;
   logic [7:0] ext_addr_hi = 8'h81, ext_ad_out = 8'h00, p1_alt_out = 8'hff, p3_alt_out = 8'hff, ext_low = 8'h00;
   logic [5:0] p5_in;
   drv_s [7:0] p1_drv, p2_drv, p3_drv, p4_drv;
   drv_s [5:0] p5_drv;
   int fail_count = 0, checks_done = 0, cycles = 0;

   quasi_bidir_port_logic dut_u (.*);
   pin_load_model load_u (.*);

   initial
   begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   // ****************************************************************
   // hang guard and shared tasks
   // ****************************************************************
   always @(posedge pclk)
   begin
      cycles <= cycles + 1;
      if (cycles == 6000)
      begin
         fail_count++;
         conclude();
      end
   end
   task automatic conclude;
      $display("checks %0d, mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      rdv = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(nm, rdv, e);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // counts boost cycles of port 1 bit 0 over a fixed window
   task automatic boosts;
      bst = 32'h0;
      repeat (8)
      begin
         @(posedge pclk);
         if (p1_drv[0].boost_pullup === 1'b1)
            bst++;
      end
   endtask
   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial
   begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      #1 chk("p1 bit 0 at release", 32'(p1_drv[0]), 32'h2);
      repeat (2) @(posedge pclk);
      #1 chk("p1 bit 0 pin high", 32'(p1_drv[0]), 32'h3);
      for (int i = 0; i < 6; i++)
         rchk("latch reset", port0_off + 12'(4 * i), (i == 5) ? 32'(latch5_rst) : 32'(latch_rst));
      rchk("analog select", ana_off, 32'(ana_rst));
      rchk("control", ctrl_off, 32'(ctrl_rst));
      apb(1'b1, 12'h0fc, 32'h0);
      chk("unmapped error", 32'(err), 32'h1);
      apb(1'b1, port1_off, 32'h000000fe);
      cyc(2);
      chk("p1 bit 0 low drive", 32'(p1_drv[0]), 32'h8);
      rchk("pin 1", pin1_off, 32'h000000fe);
      apb(1'b1, port1_off, 32'h000000ff);
      boosts();
      chk("boost cycles", bst, 32'(boost_cycles));
      apb(1'b1, port1_off, 32'h000000ff);
      boosts();
      chk("boost on reload", bst, 32'h0);
      ext_low <= 8'h02;
      cyc(4);
      rchk("latch 1", port1_off, 32'h000000ff);
      rchk("pin 1 pulled", pin1_off, 32'h000000fd);
      chk("p1 bit 1 pulled", 32'(p1_drv[1]), 32'h2);
      chk("p1 alt in", 32'(p1_alt_in), 32'h000000fd);
      chk("p5 bit 1 pulled", 32'(p5_drv[1]), 32'h2);
      ext_low <= 8'h00;
      cyc(4);
      chk("p1 bit 1 released", 32'(p1_drv[1]), 32'h3);
      apb(1'b1, ana_off, 32'h0000007f);
      cyc(2);
      chk("analog pin", 32'(p1_drv[7]), 32'h0);
      apb(1'b1, port0_off, 32'h0000000f);
      cyc(1);
      chk("port 0 i/o", 32'({p0_pullup, p0_pulldown}), 32'h00f0);
      external_access_pin <= 1'b1;
      ext_cycle <= 1'b1;
      ext_ad_drive <= 1'b1;
      ext_ad_out <= 8'ha5;
      cyc(4);
      chk("port 0 bus", 32'({p0_pullup, p0_pulldown}), 32'ha55a);
      apb(1'b1, ctrl_off, 32'h00000003);
      cyc(3);
      for (int i = 0; i < 8; i++)
         bst[i] = p2_drv[i].boost_pullup;
      chk("port 2 ones", bst & 32'hff, 32'h81);
      chk("port 2 zero", 32'(p2_drv[1].pulldown_driver), 32'h1);
      chk("port 0 bus in", 32'(ext_ad_in), 32'h000000a5);
      ext_cycle <= 1'b0;
      rchk("port 0 latch kept", port0_off, 32'h0000000f);
      apb(1'b1, ctrl_off, 32'h0);
      external_access_pin <= 1'b0;
      p3_alt_out <= 8'hfe;
      cyc(4);
      rchk("pin 3 alt", pin3_off, 32'h000000fe);
      apb(1'b1, port3_off, 32'h000000fd);
      p3_alt_out <= 8'hff;
      cyc(4);
      chk("port 3 alt in", 32'(p3_alt_in), 32'h000000fd);
      chk("p3 bit 1 low", 32'(p3_drv[1]), 32'h8);
      conclude();
   end
endmodule
